// *** hw/suf_edge_seq.sv ***
`timescale 1ns/10ps
module suf_edge_seq (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// level and result
	input wire logic level,
	output logic fire
);
	logic seen_high;
	logic prev;
	// off, on, off: fire on the falling edge after a high was seen
	assign fire = prev && !level && seen_high;
	always_ff @(posedge clk) begin
		if (srst) begin
			prev <= 1'b0;
			seen_high <= 1'b0;
		end else if (ce) begin
			prev <= level;
			if (level && !prev) begin
				seen_high <= 1'b1;
			end else if (fire) begin
				seen_high <= 1'b0;
			end
		end
	end
	chk_fire_after_fall: assert property (@(posedge clk) disable iff (srst)
		fire |-> $past(level) == 1'b1 || !ce) else $error("fire without prior high");
endmodule

// *** hw/suf_flags.sv ***
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
module suf_flags #(
	parameter int NSLV = suf_pkg::NUM_SLAVES,
	parameter int NUNIT = suf_pkg::NUM_UNITS,
	parameter int RESTART_CYCLES = suf_pkg::RESTART_CYCLES
) (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// slave link status, pin side
	input wire logic [15:0] in_slave_join,
	input wire logic [15:0] in_slave_drop,
	input wire logic [15:0] out_slave_join,
	input wire logic [15:0] out_slave_drop,
	// unit events, pin side
	input wire logic [15:0] unit_dup,
	input wire logic [15:0] unit_xfer_err,
	input wire logic word_dup,
	input wire logic [15:0] unit_on_slave_rack,
	// results
	output logic [15:0] in_data_valid,
	output logic [15:0] out_data_valid,
	output logic [15:0] refresh_en,
	output logic [15:0] unit_restarting,
	output logic irq
);
	initial begin
		if (NSLV != 16 || NUNIT != 16) $error("only 16 slaves and 16 units supported");
	end
	// two-stage synchronisers for pin inputs
	localparam int SW = 16 * 7 + 1;
	logic [SW-1:0] sync1, sync2;
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce) begin
			sync1 <= {in_slave_join, in_slave_drop, out_slave_join, out_slave_drop,
				unit_dup, unit_xfer_err, word_dup, unit_on_slave_rack};
			sync2 <= sync1;
		end
	end
	wire [15:0] s_in_join = sync2[SW-1 -: 16];
	wire [15:0] s_in_drop = sync2[SW-17 -: 16];
	wire [15:0] s_out_join = sync2[SW-33 -: 16];
	wire [15:0] s_out_drop = sync2[SW-49 -: 16];
	wire [15:0] s_dup = sync2[SW-65 -: 16];
	wire [15:0] s_xfer = sync2[SW-81 -: 16];
	wire s_word_dup = sync2[16];
	wire [15:0] s_rack = sync2[15:0];

	// software registers
	logic [15:0] in_active, in_error, out_active, out_error;
	logic [15:0] unit_error, unit_dup_flags, restart_new, restart_old, restart_alias;
	logic [15:0] refresh_dis, refresh_dis_old;
	logic fatal, summary_err, layout_old;
	logic [3:0] err_unit;
	logic [suf_pkg::IRQ_W-1:0] irq_status, irq_mask;

	wire wr_hit_new = wr && addr == suf_pkg::ADDR_RESTART_NEW;
	wire wr_hit_old = wr && addr == suf_pkg::ADDR_RESTART_OLD;
	wire wr_hit_alias = wr && addr == suf_pkg::ADDR_RESTART_ALIAS;
	wire wr_hit_rdis = wr && addr == suf_pkg::ADDR_REFRESH_DIS;
	wire wr_hit_rdold = wr && addr == suf_pkg::ADDR_REFRESH_DIS_OLD;
	wire wr_hit_layout = wr && addr == suf_pkg::ADDR_LAYOUT;
	wire wr_hit_istat = wr && addr == suf_pkg::ADDR_IRQ_STATUS;
	wire wr_hit_imask = wr && addr == suf_pkg::ADDR_IRQ_MASK;

	// restart detection per unit, either layout
	logic [15:0] fire_new, fire_old, fire_alias, restart_go, busy;
	wire [15:0] alias_lvl = restart_alias & 16'h03FF;
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_unit
			suf_restart_if rif ();
			suf_edge_seq u_new (.clk(clk), .srst(srst), .ce(ce),
				.level(restart_new[g]), .fire(fire_new[g]));
			suf_edge_seq u_old (.clk(clk), .srst(srst), .ce(ce),
				.level(restart_old[g]), .fire(fire_old[g]));
			suf_edge_seq u_alias (.clk(clk), .srst(srst), .ce(ce),
				.level(alias_lvl[g]), .fire(fire_alias[g]));
			// newer layout: set then clear; older: off-on-off, units 0-9 also via alias
			assign restart_go[g] = layout_old ? (fire_old[g] | fire_alias[g]) : fire_new[g];
			assign rif.request = restart_go[g];
			assign busy[g] = rif.busy;
			suf_restart_unit #(.CYCLES(RESTART_CYCLES)) u_rst (.clk(clk), .srst(srst),
				.ce(ce), .rif(rif));
		end
	endgenerate

	// any restart clears slave flags, as power-on does
	wire restart_any = |restart_go;
	wire [15:0] dup_err = s_dup | s_xfer;
	wire any_err = |dup_err;
	logic [3:0] next_err_unit;
	always_comb begin
		next_err_unit = err_unit;
		for (int i = 15; i >= 0; i--) begin
			if (dup_err[i]) next_err_unit = 4'(i);
		end
	end
	wire [15:0] dis_eff = layout_old ? (refresh_dis_old | (refresh_dis & 16'h03FF)) : refresh_dis;
	wire [suf_pkg::IRQ_W-1:0] irq_ev = {fatal == 1'b0 && (|s_dup || s_word_dup),
		any_err, |((s_in_drop & in_active) | (s_out_drop & out_active))};

	always_ff @(posedge clk) begin
		if (srst) begin
			{in_active, in_error, out_active, out_error} <= '0;
			{unit_error, unit_dup_flags, restart_new, restart_old, restart_alias} <= '0;
			{refresh_dis, refresh_dis_old, fatal, summary_err, layout_old, err_unit} <= '0;
			{irq_status, irq_mask} <= '0;
		end else if (ce) begin
			if (restart_any) begin
				{in_active, in_error, out_active, out_error} <= '0;
			end else begin
				in_active <= in_active | s_in_join;
				out_active <= out_active | s_out_join;
				// dropout of an active slave sets the error; rejoin restores normal
				in_error <= (in_error & ~s_in_join) | (s_in_drop & in_active);
				out_error <= (out_error & ~s_out_join) | (s_out_drop & out_active);
			end
			if (|s_dup || s_word_dup) fatal <= 1'b1;
			unit_dup_flags <= unit_dup_flags | s_dup;
			unit_error <= unit_error | dup_err;
			if (any_err) begin
				summary_err <= 1'b1;
				err_unit <= next_err_unit;
			end
			if (wr_hit_new) restart_new <= wdata[15:0];
			if (wr_hit_old) restart_old <= wdata[15:0];
			if (wr_hit_alias) restart_alias <= wdata[15:0];
			if (wr_hit_rdis) refresh_dis <= wdata[15:0];
			if (wr_hit_rdold) refresh_dis_old <= wdata[15:0];
			if (wr_hit_layout) layout_old <= wdata[suf_pkg::LAYOUT_OLD_BIT];
			if (wr_hit_imask) irq_mask <= wdata[suf_pkg::IRQ_W-1:0];
			// set wins over the write-one clear
			irq_status <= (irq_status & ~(wr_hit_istat ? wdata[suf_pkg::IRQ_W-1:0] : '0))
				| irq_ev;
		end
	end

	// read decode
	logic [15:0] rword;
	always_comb begin
		if (addr == suf_pkg::ADDR_IN_ACTIVE) rword = in_active;
		else if (addr == suf_pkg::ADDR_IN_ERROR) rword = in_error;
		else if (addr == suf_pkg::ADDR_OUT_ACTIVE) rword = out_active;
		else if (addr == suf_pkg::ADDR_OUT_ERROR) rword = out_error;
		else if (addr == suf_pkg::ADDR_RESTARTING) rword = busy;
		else if (addr == suf_pkg::ADDR_UNIT_ERROR) rword = unit_error;
		else if (addr == suf_pkg::ADDR_UNIT_DUP) rword = unit_dup_flags;
		else if (addr == suf_pkg::ADDR_SUMMARY) rword = {14'h0000, summary_err, fatal};
		else if (addr == suf_pkg::ADDR_ERR_UNIT) rword = {12'h000, err_unit};
		else if (addr == suf_pkg::ADDR_RESTART_NEW) rword = restart_new;
		else if (addr == suf_pkg::ADDR_RESTART_OLD) rword = restart_old;
		// alias word reads back restart_alias; unit errors 0-9 mirror at the alias address plus 0x40 in either layout
		else if (addr == suf_pkg::ADDR_RESTART_ALIAS) rword = restart_alias;
		else if (addr == suf_pkg::ADDR_REFRESH_DIS) rword = refresh_dis;
		else if (addr == suf_pkg::ADDR_REFRESH_DIS_OLD) rword = refresh_dis_old;
		else if (addr == suf_pkg::ADDR_LAYOUT) rword = {15'h0000, layout_old};
		else if (addr == suf_pkg::ADDR_IRQ_STATUS) rword = {13'h0000, irq_status};
		else if (addr == suf_pkg::ADDR_IRQ_MASK) rword = {13'h0000, irq_mask};
		else rword = suf_pkg::ZERO16;
	end
	wire [15:0] unit_err_alias = unit_error & 16'h03FF;
	wire [15:0] rword_sel = (addr == suf_pkg::ADDR_RESTART_ALIAS + 8'h40) ? unit_err_alias : rword;

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= 32'h00000000;
			in_data_valid <= 16'h0000;
			out_data_valid <= 16'h0000;
			refresh_en <= 16'h0000;
			unit_restarting <= 16'h0000;
			irq <= 1'b0;
		end else if (ce) begin
			rdata <= rd ? {16'h0000, rword_sel} : 32'h00000000;
			in_data_valid <= in_active & ~in_error;
			out_data_valid <= out_active & ~out_error;
			refresh_en <= ~dis_eff | s_rack;
			unit_restarting <= busy;
			irq <= |(irq_status & irq_mask);
		end
	end

	chk_active_sticky: assert property (@(posedge clk) disable iff (srst)
		ce && !restart_any && in_active[0] |=> in_active[0]) else $error("active dropped");
	chk_restart_clears: assert property (@(posedge clk) disable iff (srst)
		ce && restart_any |=> in_error == 16'h0000 && out_active == 16'h0000) else
		$error("restart left flags");
	chk_valid_needs_active: assert property (@(posedge clk) disable iff (srst)
		in_data_valid[0] |-> $past(in_active[0])) else $error("valid before active");
	chk_fatal_on_dup: assert property (@(posedge clk) disable iff (srst)
		ce && s_word_dup |=> fatal) else $error("fatal not raised");
	chk_summary_on_err: assert property (@(posedge clk) disable iff (srst)
		ce && any_err |=> summary_err && unit_error != 16'h0000) else
		$error("summary not set");
	chk_dup_flags: assert property (@(posedge clk) disable iff (srst)
		ce && s_dup[3] |=> unit_dup_flags[3] && unit_error[3]) else
		$error("dup flag missing");
	chk_restarting_held: assert property (@(posedge clk) disable iff (srst)
		ce && restart_go[2] |=> ##1 unit_restarting[2]) else $error("restarting not shown");
	chk_refresh_off: assert property (@(posedge clk) disable iff (srst)
		ce && !layout_old && refresh_dis[11] && !s_rack[11] |=> !refresh_en[11]) else
		$error("refresh not disabled");
	cov_restart_new: cover property (@(posedge clk) ce && !layout_old && restart_go[1]);
	cov_restart_alias: cover property (@(posedge clk) ce && layout_old && fire_alias[2]);
	cov_slave_drop: cover property (@(posedge clk) ce && |in_error);
	cov_irq: cover property (@(posedge clk) irq);
endmodule

// *** hw/suf_pkg.sv ***
package suf_pkg;
	localparam int NUM_SLAVES = 16;
	localparam int NUM_UNITS = 16;
	localparam int ALIAS_UNITS = 10;
	localparam int UNIT_NUM_W = 4;
	// register offsets, byte address; word index is address divided by four
	localparam logic [7:0] ADDR_IN_ACTIVE = 8'h00;
	localparam logic [7:0] ADDR_IN_ERROR = 8'h04;
	localparam logic [7:0] ADDR_OUT_ACTIVE = 8'h08;
	localparam logic [7:0] ADDR_OUT_ERROR = 8'h0C;
	localparam logic [7:0] ADDR_RESTARTING = 8'h10;
	localparam logic [7:0] ADDR_UNIT_ERROR = 8'h14;
	localparam logic [7:0] ADDR_UNIT_DUP = 8'h18;
	localparam logic [7:0] ADDR_SUMMARY = 8'h1C;
	localparam logic [7:0] ADDR_ERR_UNIT = 8'h20;
	localparam logic [7:0] ADDR_RESTART_NEW = 8'h24;
	localparam logic [7:0] ADDR_RESTART_OLD = 8'h28;
	localparam logic [7:0] ADDR_RESTART_ALIAS = 8'h2C;
	localparam logic [7:0] ADDR_REFRESH_DIS = 8'h30;
	localparam logic [7:0] ADDR_REFRESH_DIS_OLD = 8'h34;
	localparam logic [7:0] ADDR_LAYOUT = 8'h38;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h3C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
	// summary word fields
	localparam int SUM_FATAL_BIT = 0;
	localparam int SUM_UNIT_ERR_BIT = 1;
	// interrupt status fields
	localparam int IRQ_W = 3;
	localparam int IRQ_SLAVE_ERR_BIT = 0;
	localparam int IRQ_UNIT_ERR_BIT = 1;
	localparam int IRQ_FATAL_BIT = 2;
	// layout select: 0 newer, 1 older
	localparam int LAYOUT_OLD_BIT = 0;
	localparam logic [15:0] ZERO16 = 16'h0000;
	// restart duration in cycles of a 50 MHz clock
	localparam int CLK_HZ = 50000000;
	localparam int RESTART_US = 10;
	localparam int RESTART_CYCLES = (RESTART_US * (CLK_HZ / 1000000));
endpackage

// *** hw/suf_restart_if.sv ***
`timescale 1ns/10ps
interface suf_restart_if;
	logic request;
	logic busy;
	modport ctrl (output request, input busy);
	modport unit (input request, output busy);
endinterface

// *** hw/suf_restart_unit.sv ***
`timescale 1ns/10ps
module suf_restart_unit #(
	parameter int CYCLES = suf_pkg::RESTART_CYCLES
) (
	// clocking
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	// handshake
	suf_restart_if.unit rif
);
	initial begin
		if (CYCLES < 1) $error("CYCLES must be at least one");
	end
	logic [31:0] count;
	logic busy_q;
	assign rif.busy = busy_q;
	// busy from request until the count has run out
	always_ff @(posedge clk) begin
		if (srst) begin
			busy_q <= 1'b0;
			count <= 32'h00000000;
		end else if (ce) begin
			if (rif.request) begin
				busy_q <= 1'b1;
				count <= 32'(CYCLES - 1);
			end else if (busy_q && count != 32'h00000000) begin
				count <= count - 32'h00000001;
			end else begin
				busy_q <= 1'b0;
			end
		end
	end
	chk_busy_on_request: assert property (@(posedge clk) disable iff (srst)
		ce && rif.request |=> rif.busy) else $error("restart busy not set");
endmodule

// *** test/slave_and_unit_status_flags_test.sv ***
`timescale 1ns/10ps
module slave_and_unit_status_flags_test;
	localparam int RCYC = 4;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [15:0] mask = 16'h0000;
	logic [15:0] rack = 16'h0000;
	logic [31:0] rdata;
	logic [15:0] ij, id, oj, od, dup, xe, in_v, out_v, ref_en, rst_u;
	logic wdup, irq;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;

	initial begin
		forever #10 clk = ~clk;
	end

	suf_field_model fm_u (.clk(clk), .go(go), .sel(sel), .mask(mask), .in_join(ij),
		.in_drop(id), .out_join(oj), .out_drop(od), .dup(dup), .xfer(xe), .wdup(wdup));

	// short restart keeps the run small; expectations use RCYC
	suf_flags #(.RESTART_CYCLES(RCYC)) dut_u (.clk(clk), .srst(srst), .ce(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.in_slave_join(ij), .in_slave_drop(id), .out_slave_join(oj), .out_slave_drop(od),
		.unit_dup(dup), .unit_xfer_err(xe), .word_dup(wdup), .unit_on_slave_rack(rack),
		.in_data_valid(in_v), .out_data_valid(out_v), .refresh_en(ref_en),
		.unit_restarting(rst_u), .irq(irq));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(name, rdata, exp);
	endtask

	// pins pass two sync flops and a register before they show
	task automatic settle();
		repeat (6) @(posedge clk);
		#1;
	endtask

	task automatic ev(input logic [2:0] s, input logic [15:0] m);
		@(posedge clk);
		go <= 1'b1;
		sel <= s;
		mask <= m;
		@(posedge clk);
		go <= 1'b0;
		settle();
	endtask

	task automatic do_rst(input logic [7:0] a, input int n, input logic [15:0] exp);
		int k;
		wr_reg(a, 32'h00000001 << n);
		settle();
		chk("restart before clear", {16'h0000, rst_u}, 32'h00000000);
		wr_reg(a, 32'h00000000);
		k = 0;
		while (rst_u === 16'h0000 && k < 20) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("restarting flag", {16'h0000, rst_u}, {16'h0000, exp});
		k = 0;
		while (rst_u !== 16'h0000 && k < 20) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("restart length", 32'(k), 32'(RCYC));
	endtask

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i <= 16; i++) begin
			rd_chk(8'(i * 4), 32'h00000000, "reset value");
		end
		wr_reg(8'h50, 32'h0000FFFF);
		rd_chk(8'h50, 32'h00000000, "unmapped");
		// drop on inactive slave 1 must stay invisible
		ev(3'h0, 16'h0005);
		ev(3'h2, 16'h8001);
		rd_chk(suf_pkg::ADDR_IN_ACTIVE, 32'h00000005, "in active");
		rd_chk(suf_pkg::ADDR_OUT_ACTIVE, 32'h00008001, "out active");
		chk("in valid", {16'h0000, in_v}, 32'h00000005);
		chk("out valid", {16'h0000, out_v}, 32'h00008001);
		ev(3'h1, 16'h0006);
		ev(3'h3, 16'h8000);
		rd_chk(suf_pkg::ADDR_IN_ERROR, 32'h00000004, "in error");
		rd_chk(suf_pkg::ADDR_OUT_ERROR, 32'h00008000, "out error");
		rd_chk(suf_pkg::ADDR_IN_ACTIVE, 32'h00000005, "active after drop");
		chk("valid after drop", {16'h0000, in_v}, 32'h00000001);
		rd_chk(suf_pkg::ADDR_IRQ_STATUS, 32'h00000001, "irq status");
		// a mask bit of one lets its status bit through
		chk("irq masked", {31'h0, irq}, 32'h00000000);
		wr_reg(suf_pkg::ADDR_IRQ_MASK, 32'h00000001);
		settle();
		chk("irq high", {31'h0, irq}, 32'h00000001);
		wr_reg(suf_pkg::ADDR_IRQ_MASK, 32'h00000000);
		settle();
		chk("irq masked again", {31'h0, irq}, 32'h00000000);
		wr_reg(suf_pkg::ADDR_IRQ_MASK, 32'h00000001);
		settle();
		chk("irq unmasked", {31'h0, irq}, 32'h00000001);
		wr_reg(suf_pkg::ADDR_IRQ_STATUS, 32'h00000001);
		settle();
		chk("irq cleared", {31'h0, irq}, 32'h00000000);
		rd_chk(suf_pkg::ADDR_IRQ_STATUS, 32'h00000000, "status cleared");
		ev(3'h0, 16'h0004);
		rd_chk(suf_pkg::ADDR_IN_ERROR, 32'h00000000, "rejoin");
		ev(3'h5, 16'h0080);
		rd_chk(suf_pkg::ADDR_UNIT_ERROR, 32'h00000080, "unit error");
		rd_chk(suf_pkg::ADDR_UNIT_DUP, 32'h00000000, "no dup");
		rd_chk(suf_pkg::ADDR_SUMMARY, 32'h00000002, "summary xfer");
		rd_chk(suf_pkg::ADDR_ERR_UNIT, 32'h00000007, "err unit");
		ev(3'h6, 16'h0000);
		rd_chk(suf_pkg::ADDR_SUMMARY, 32'h00000003, "fatal word");
		ev(3'h4, 16'h0028);
		rd_chk(suf_pkg::ADDR_UNIT_DUP, 32'h00000028, "unit dup");
		rd_chk(suf_pkg::ADDR_UNIT_ERROR, 32'h000000A8, "dup error");
		rd_chk(suf_pkg::ADDR_ERR_UNIT, 32'h00000003, "dup err unit");
		rd_chk(suf_pkg::ADDR_IRQ_STATUS, 32'h00000006, "unit irq");
		@(posedge clk);
		rack <= 16'h0002;
		wr_reg(suf_pkg::ADDR_REFRESH_DIS, 32'h00000803);
		settle();
		chk("refresh new", {16'h0000, ref_en}, 32'h0000F7FE);
		do_rst(suf_pkg::ADDR_RESTART_NEW, 2, 16'h0004);
		rd_chk(suf_pkg::ADDR_IN_ACTIVE, 32'h00000000, "cleared by restart");
		rd_chk(suf_pkg::ADDR_OUT_ERROR, 32'h00000000, "error cleared");
		wr_reg(suf_pkg::ADDR_LAYOUT, 32'h00000001);
		rd_chk(8'h6C, 32'h000000A8, "error alias");
		rd_chk(suf_pkg::ADDR_SUMMARY, 32'h00000003, "old summary");
		rd_chk(suf_pkg::ADDR_ERR_UNIT, 32'h00000003, "old err unit");
		wr_reg(suf_pkg::ADDR_REFRESH_DIS, 32'h00000C01);
		wr_reg(suf_pkg::ADDR_REFRESH_DIS_OLD, 32'h00000010);
		settle();
		chk("refresh old", {16'h0000, ref_en}, 32'h0000FFEE);
		do_rst(suf_pkg::ADDR_RESTART_OLD, 12, 16'h1000);
		do_rst(suf_pkg::ADDR_RESTART_ALIAS, 9, 16'h0200);
		finish_test();
	end
endmodule

// *** test/suf_field_model.sv ***
`timescale 1ns/10ps
// field side: slave network and unit events as one-cycle pulses
// pulses last a full cycle so the design's two-flop syncs never miss one
module suf_field_model (
	// clocking
	input wire logic clk,
	// request from bench
	input wire logic go,
	input wire logic [2:0] sel,
	input wire logic [15:0] mask,
	// pins toward the design
	output logic [15:0] in_join,
	output logic [15:0] in_drop,
	output logic [15:0] out_join,
	output logic [15:0] out_drop,
	output logic [15:0] dup,
	output logic [15:0] xfer,
	output logic wdup
);
	initial begin
		{in_join, in_drop, out_join, out_drop, dup, xfer, wdup} = '0;
	end
	always_ff @(posedge clk) begin
		in_join <= (go && sel == 3'h0) ? mask : 16'h0000;
		in_drop <= (go && sel == 3'h1) ? mask : 16'h0000;
		out_join <= (go && sel == 3'h2) ? mask : 16'h0000;
		out_drop <= (go && sel == 3'h3) ? mask : 16'h0000;
		dup <= (go && sel == 3'h4) ? mask : 16'h0000;
		xfer <= (go && sel == 3'h5) ? mask : 16'h0000;
		wdup <= go && sel == 3'h6;
	end
endmodule
